// >>> src/rpss_defs.svh
// Constants of the ramp phase and spread-spectrum configuration block.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
`ifndef RPSS_DEFS_SVH
`define RPSS_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RPSS_IDX_OPCOND 8'h68
`define RPSS_IDX_MUTE 8'h69
`define RPSS_IDX_PHASE 8'h6A
`define RPSS_IDX_SSA 8'h6B
`define RPSS_IDX_SSB 8'h6C
`define RPSS_IDX_DIV 8'h6D
`define RPSS_IDX_STEP 8'h6E
`define RPSS_IDX_AMPB 8'h6F
`define RPSS_IDX_IRQ_STAT 8'h80
`define RPSS_IDX_IRQ_CLR 8'h81
`define RPSS_IDX_IRQ_EN 8'h82

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPSS_RST_ZERO 8'h00
`define RPSS_RST_DIV 8'hA0
`define RPSS_RST_STEP 8'h11
`define RPSS_RST_AMPB 8'h24
`define RPSS_RST_IRQ 4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPSS_PH_SEL 3:2
`define RPSS_SYNC_SEL 1
`define RPSS_SYNC_EN 0
`define RPSS_PRE_DIV 5
`define RPSS_MANUAL 4
`define RPSS_RDM_EN 1
`define RPSS_TRI_EN 0
`define RPSS_DITHER 6:4
`define RPSS_TRI_CTRL 3:0
`define RPSS_FALL 7:4
`define RPSS_RISE 3:0
`define RPSS_AMP 6:5
`define RPSS_PERIOD 4:0
`define RPSS_MUTE_R 1
`define RPSS_MUTE_L 0
`define RPSS_EVT 3:0

// ----------------------------------------------------------------
// Codes and event bits
// ----------------------------------------------------------------
`define RPSS_OP_PLAY 8'h03
`define RPSS_OP_MAX 8'h03
`define RPSS_EV_MUTE_L 0
`define RPSS_EV_MUTE_R 1
`define RPSS_EV_STATE 2
`define RPSS_EV_SYNC 3
`define RPSS_RESP_OKAY 2'h0
`define RPSS_RESP_SLVERR 2'h2

`endif

// >>> src/rpss_pkg.sv
// Types of the ramp phase and spread-spectrum configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rpss_pkg;
    // Settings that steer the ramp generator, after mode selection
    typedef struct packed {
        logic [1:0] phase;
        logic sync_internal;
        logic sync_enable;
        logic manual_mode;
        logic pre_div2;
        logic triangle_enable;
        logic random_spread_enable;
        logic [3:0] triangle_ctrl;
        logic [2:0] dither_amount;
        logic [7:0] ramp_divisor;
        logic [3:0] triangle_fall_step;
        logic [3:0] triangle_rise_step;
        logic [1:0] ramp_amplitude;
        logic [4:0] triangle_period_limit;
    } rpss_ramp_cfg_t;

    typedef struct packed {
        logic left_silence_flag;
        logic right_silence_flag;
    } rpss_mute_t;
endpackage
`default_nettype wire

// >>> src/rpss_top.sv
// Ramp phase, phase sync and spread-spectrum setup with state reports.
// Assumes operating state, mute flags and internal sync tick come from
// logic on CLOCK; the sync pin is asynchronous and gets synchronised.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "rpss_defs.svh"
`default_nettype none
module rpss_top #(
    parameter int AW = 12
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    // AXI4-Lite slave
    input wire logic [AW-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AW-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Device status
    input wire logic [7:0] OPERATING_CONDITION_CODE,
    input wire rpss_pkg::rpss_mute_t SILENCE_FLAGS,
    input wire logic INTERNAL_SYNC_TICK,
    input wire logic SYNC_PIN,
    // Ramp generator control
    output rpss_pkg::rpss_ramp_cfg_t RAMP_CFG,
    output logic RAMP_SYNC_PULSE,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [AW-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = AW'({idx, 2'b00});
    endfunction

    // Byte offset ignored: every register is one aligned word
    function automatic logic hit(input logic [AW-1:0] addr, input logic [7:0] idx);
        logic [AW-1:0] base;
        base = byte_addr(idx);
        hit = (addr[AW-1:2] == base[AW-1:2]);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] phase_q;
    logic [7:0] ssa_q;
    logic [7:0] ssb_q;
    logic [7:0] div_q;
    logic [7:0] step_q;
    logic [7:0] ampb_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [3:0] irq_en_q;
    logic [7:0] op_code_q;
    logic [1:0] mute_q;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic aw_held_q;
    logic w_held_q;
    logic awready_q;
    logic wready_q;
    logic [AW-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Ready is offered one cycle after valid so that it comes from a flop
    wire aw_offer = S_AXI_AWVALID && !aw_held_q && !bvalid_q && !awready_q;
    wire w_offer = S_AXI_WVALID && !w_held_q && !bvalid_q && !wready_q;
    wire aw_take = S_AXI_AWVALID && awready_q;
    wire w_take = S_AXI_WVALID && wready_q;
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire wr_en = do_write && wlane_q;
    wire wr_phase = wr_en && hit(awaddr_q, `RPSS_IDX_PHASE);
    wire wr_ssa = wr_en && hit(awaddr_q, `RPSS_IDX_SSA);
    wire wr_ssb = wr_en && hit(awaddr_q, `RPSS_IDX_SSB);
    wire wr_div = wr_en && hit(awaddr_q, `RPSS_IDX_DIV);
    wire wr_step = wr_en && hit(awaddr_q, `RPSS_IDX_STEP);
    wire wr_ampb = wr_en && hit(awaddr_q, `RPSS_IDX_AMPB);
    wire wr_clr = wr_en && hit(awaddr_q, `RPSS_IDX_IRQ_CLR);
    wire wr_ien = wr_en && hit(awaddr_q, `RPSS_IDX_IRQ_EN);
    wire w_mapped = hit(awaddr_q, `RPSS_IDX_OPCOND) || hit(awaddr_q, `RPSS_IDX_MUTE)
        || hit(awaddr_q, `RPSS_IDX_PHASE) || hit(awaddr_q, `RPSS_IDX_SSA)
        || hit(awaddr_q, `RPSS_IDX_SSB) || hit(awaddr_q, `RPSS_IDX_DIV)
        || hit(awaddr_q, `RPSS_IDX_STEP) || hit(awaddr_q, `RPSS_IDX_AMPB)
        || hit(awaddr_q, `RPSS_IDX_IRQ_STAT) || hit(awaddr_q, `RPSS_IDX_IRQ_CLR)
        || hit(awaddr_q, `RPSS_IDX_IRQ_EN);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b0;
            awaddr_q <= '0;
        end else begin
            awready_q <= aw_offer;
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b0;
            wbyte_q <= `RPSS_RST_ZERO;
            wlane_q <= 1'b0;
        end else begin
            wready_q <= w_offer;
            if (w_take) begin
                w_held_q <= 1'b1;
                wbyte_q <= S_AXI_WDATA[7:0];
                wlane_q <= S_AXI_WSTRB[0];
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response waits for both halves, in whichever order they came
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RPSS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= w_mapped ? `RPSS_RESP_OKAY : `RPSS_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Reserved bits are kept so software reads back what it wrote
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            phase_q <= `RPSS_RST_ZERO;
            ssa_q <= `RPSS_RST_ZERO;
            ssb_q <= `RPSS_RST_ZERO;
        end else begin
            if (wr_phase) begin
                phase_q <= wbyte_q;
            end
            if (wr_ssa) begin
                ssa_q <= wbyte_q;
            end
            if (wr_ssb) begin
                ssb_q <= wbyte_q;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            div_q <= `RPSS_RST_DIV;
            step_q <= `RPSS_RST_STEP;
            ampb_q <= `RPSS_RST_AMPB;
        end else begin
            if (wr_div) begin
                div_q <= wbyte_q;
            end
            if (wr_step) begin
                step_q <= wbyte_q;
            end
            if (wr_ampb) begin
                ampb_q <= wbyte_q;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            irq_en_q <= `RPSS_RST_IRQ;
        end else if (wr_ien) begin
            irq_en_q <= wbyte_q[`RPSS_EVT];
        end
    end

    // ------------------------------------------------------------
    // Status capture and events
    // ------------------------------------------------------------
    logic sync_meta_q;
    logic sync_pin_q;
    logic sync_pin_d1_q;
    logic sync_pulse_q;
    logic irq_q;
    wire pin_rise = sync_pin_q && !sync_pin_d1_q;
    wire sync_src = phase_q[`RPSS_SYNC_SEL] ? INTERNAL_SYNC_TICK : pin_rise;
    wire sync_fire = phase_q[`RPSS_SYNC_EN] && sync_src;
    wire state_change = (OPERATING_CONDITION_CODE != op_code_q);
    wire [3:0] events = {sync_fire, state_change,
        SILENCE_FLAGS.right_silence_flag && !mute_q[`RPSS_MUTE_R],
        SILENCE_FLAGS.left_silence_flag && !mute_q[`RPSS_MUTE_L]};
    wire [3:0] clr_mask = wr_clr ? wbyte_q[`RPSS_EVT] : 4'h0;
    // New events beat a simultaneous clear
    assign irq_stat_d = (irq_stat_q & ~clr_mask) | events;

    // Two flops before anything reads the pin; the third only finds the edge
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync_meta_q <= 1'b0;
            sync_pin_q <= 1'b0;
            sync_pin_d1_q <= 1'b0;
        end else begin
            sync_meta_q <= SYNC_PIN;
            sync_pin_q <= sync_meta_q;
            sync_pin_d1_q <= sync_pin_q;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync_pulse_q <= 1'b0;
            op_code_q <= `RPSS_RST_ZERO;
            mute_q <= 2'h0;
            irq_stat_q <= `RPSS_RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            sync_pulse_q <= sync_fire;
            op_code_q <= OPERATING_CONDITION_CODE;
            mute_q[`RPSS_MUTE_R] <= SILENCE_FLAGS.right_silence_flag;
            mute_q[`RPSS_MUTE_L] <= SILENCE_FLAGS.left_silence_flag;
            irq_stat_q <= irq_stat_d;
            // Level output follows the status as it is written
            irq_q <= |(irq_stat_d & irq_en_q);
        end
    end

    // ------------------------------------------------------------
    // Ramp settings after mode selection
    // ------------------------------------------------------------
    wire manual = ssa_q[`RPSS_MANUAL];
    wire in_play = (op_code_q == `RPSS_OP_PLAY);
    rpss_pkg::rpss_ramp_cfg_t cfg_d;
    rpss_pkg::rpss_ramp_cfg_t cfg_q;

    // Phase frozen during play so a running ramp never jumps
    // phase select
    assign cfg_d.phase = in_play ? cfg_q.phase : phase_q[`RPSS_PH_SEL];
    assign cfg_d.sync_internal = phase_q[`RPSS_SYNC_SEL];
    assign cfg_d.sync_enable = phase_q[`RPSS_SYNC_EN];
    assign cfg_d.manual_mode = manual;
    // divide by two only in manual
    assign cfg_d.pre_div2 = manual && ssa_q[`RPSS_PRE_DIV];
    assign cfg_d.triangle_enable = ssa_q[`RPSS_TRI_EN];
    assign cfg_d.random_spread_enable = ssa_q[`RPSS_RDM_EN];
    assign cfg_d.triangle_ctrl = ssb_q[`RPSS_TRI_CTRL];
    assign cfg_d.dither_amount = ssb_q[`RPSS_DITHER];
    // Automatic mode runs on the default manual values
    wire [7:0] step_dflt = `RPSS_RST_STEP;
    wire [7:0] ampb_dflt = `RPSS_RST_AMPB;
    assign cfg_d.ramp_divisor = manual ? div_q : `RPSS_RST_DIV;
    assign cfg_d.triangle_fall_step = manual ? step_q[`RPSS_FALL] : step_dflt[`RPSS_FALL];
    assign cfg_d.triangle_rise_step = manual ? step_q[`RPSS_RISE] : step_dflt[`RPSS_RISE];
    assign cfg_d.ramp_amplitude = manual ? ampb_q[`RPSS_AMP] : ampb_dflt[`RPSS_AMP];
    assign cfg_d.triangle_period_limit = manual ? ampb_q[`RPSS_PERIOD] : ampb_dflt[`RPSS_PERIOD];

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cfg_q <= '0;
        end else begin
            // only named fields reach the ramp
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic arready_q;
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;
    // Data is fetched at the address handshake, so RVALID never leads it
    wire ar_offer = S_AXI_ARVALID && !rvalid_q && !arready_q;
    wire ar_hs = S_AXI_ARVALID && arready_q;
    wire [AW-1:0] ra = S_AXI_ARADDR;
    wire r_opc = hit(ra, `RPSS_IDX_OPCOND);
    wire r_mute = hit(ra, `RPSS_IDX_MUTE);
    wire r_ph = hit(ra, `RPSS_IDX_PHASE);
    wire r_ssa = hit(ra, `RPSS_IDX_SSA);
    wire r_ssb = hit(ra, `RPSS_IDX_SSB);
    wire r_div = hit(ra, `RPSS_IDX_DIV);
    wire r_step = hit(ra, `RPSS_IDX_STEP);
    wire r_ampb = hit(ra, `RPSS_IDX_AMPB);
    wire r_ist = hit(ra, `RPSS_IDX_IRQ_STAT);
    wire r_clr = hit(ra, `RPSS_IDX_IRQ_CLR);
    wire r_ien = hit(ra, `RPSS_IDX_IRQ_EN);
    wire r_mapped = r_opc || r_mute || r_ph || r_ssa || r_ssb || r_div || r_step
        || r_ampb || r_ist || r_clr || r_ien;
    // Clear register is write-only and reads as zero
    wire [7:0] rsel = ({8{r_opc}} & op_code_q)
        | ({8{r_mute}} & {6'h00, mute_q})
        | ({8{r_ph}} & phase_q)
        | ({8{r_ssa}} & ssa_q)
        | ({8{r_ssb}} & ssb_q)
        | ({8{r_div}} & div_q)
        | ({8{r_step}} & step_q)
        | ({8{r_ampb}} & ampb_q)
        | ({8{r_ist}} & {4'h0, irq_stat_q})
        | ({8{r_ien}} & {4'h0, irq_en_q});

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= `RPSS_RST_ZERO;
            rresp_q <= `RPSS_RESP_OKAY;
        end else begin
            arready_q <= ar_offer;
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rsel;
                rresp_q <= r_mapped ? `RPSS_RESP_OKAY : `RPSS_RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = {24'h000000, rdata_q};
    assign S_AXI_RRESP = rresp_q;
    assign RAMP_CFG = cfg_q;
    assign RAMP_SYNC_PULSE = sync_pulse_q;
    assign IRQ = irq_q;

endmodule
`default_nettype wire

// >>> verification/rpss_top_chk.sv
// Port-level assertions for the ramp phase and spread setup block.
// Assumes one clock domain and the synchronous active-low reset.
`default_nettype none
module rpss_top_chk #(
    parameter int AW = 12
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] OPERATING_CONDITION_CODE,
    input wire rpss_pkg::rpss_mute_t SILENCE_FLAGS,
    input wire logic INTERNAL_SYNC_TICK,
    input wire rpss_pkg::rpss_ramp_cfg_t RAMP_CFG,
    input wire logic RAMP_SYNC_PULSE,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    // ----------
    // Reports
    // ----------
    state_read_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == AW'(12'h1A0)
        |=> S_AXI_RVALID && S_AXI_RDATA == {24'h000000, $past(OPERATING_CONDITION_CODE, 2)})
        else $error("state report mismatch");
    mute_read_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == AW'(12'h1A4)
        |=> S_AXI_RVALID && S_AXI_RDATA == {30'h0, $past(SILENCE_FLAGS.right_silence_flag, 2),
            $past(SILENCE_FLAGS.left_silence_flag, 2)})
        else $error("mute report mismatch");

    // ----------
    // Ramp control
    // ----------
    sync_gate_a: assert property (
        RAMP_SYNC_PULSE |-> RAMP_CFG.sync_enable || $past(RAMP_CFG.sync_enable))
        else $error("sync pulse while disabled");
    int_sync_a: assert property (
        INTERNAL_SYNC_TICK ##1 (RAMP_CFG.sync_enable && RAMP_CFG.sync_internal)
        |-> RAMP_SYNC_PULSE)
        else $error("internal tick not followed");
    auto_fields_a: assert property (
        $past(RST_N) && !RAMP_CFG.manual_mode |-> RAMP_CFG.ramp_divisor == 8'hA0
        && RAMP_CFG.triangle_fall_step == 4'h1 && RAMP_CFG.triangle_rise_step == 4'h1
        && RAMP_CFG.ramp_amplitude == 2'h1 && RAMP_CFG.triangle_period_limit == 5'h04)
        else $error("manual field leaks into auto mode");
    prediv_mode_a: assert property (
        RAMP_CFG.pre_div2 |-> RAMP_CFG.manual_mode)
        else $error("divide by two outside manual mode");
    reset_cfg_a: assert property (
        $rose(RST_N) |=> !RAMP_CFG.sync_enable && !RAMP_CFG.manual_mode
        && RAMP_CFG.phase == 2'h0 && RAMP_CFG.triangle_ctrl == 4'h0)
        else $error("configuration not at defaults");
    phase_hold_a: assert property (
        $past(OPERATING_CONDITION_CODE) == 8'h03
        && $past(OPERATING_CONDITION_CODE, 2) == 8'h03 |-> $stable(RAMP_CFG.phase))
        else $error("phase moved during play");

    cover property (INTERNAL_SYNC_TICK ##1 RAMP_SYNC_PULSE);
    cover property ($rose(IRQ));
    cover property (RAMP_CFG.manual_mode && RAMP_CFG.pre_div2);
    cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind rpss_top rpss_top_chk #(.AW(AW)) chk (.*);
`default_nettype wire

// >>> verification/rpss_top_bench.sv
// Self-checking bench for the ramp phase and spread setup block.
// Assumes package, design top and checker are compiled before it.
`default_nettype none
module rpss_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [11:0] S_AXI_AWADDR = 12'h000;
    logic [11:0] S_AXI_ARADDR = 12'h000;
    logic [31:0] S_AXI_WDATA = 32'h00000000;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic INTERNAL_SYNC_TICK = 1'b0, SYNC_PIN = 1'b0;
    logic [7:0] OPERATING_CONDITION_CODE = 8'h00;
    rpss_pkg::rpss_mute_t SILENCE_FLAGS = 2'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic RAMP_SYNC_PULSE, IRQ;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    rpss_pkg::rpss_ramp_cfg_t RAMP_CFG, ecfg;
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'hA0, 8'h11, 8'h24};
    logic [1:0] fph = 2'h0;
    int err_total = 0;
    int comparisons = 0;

    always #2.5 CLOCK = ~CLOCK;

    rpss_top #(.AW(12)) uut (.S_AXI_AWPROT(3'h0), .S_AXI_WSTRB(4'hF), .S_AXI_ARPROT(3'h0), .*);

    // ----------
    // Tasks
    // ----------
    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t ns: got %0h expected %0h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tmo();
        err_total++;
        $display("[FAIL] %0t ns: bus answer missing", $time);
        results();
    endtask

    // Handshakes judged at the falling edge, released after the rising one
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ah = 1'b0;
        logic wh = 1'b0;
        logic bh = 1'b0;
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h000000, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (int n = 0; n < 40 && !bh; n++) begin
            @(negedge CLOCK);
            ah = S_AXI_AWVALID && S_AXI_AWREADY;
            wh = S_AXI_WVALID && S_AXI_WREADY;
            bh = S_AXI_BVALID;
            if (bh) cmp(S_AXI_BRESP, r);
            @(posedge CLOCK);
            if (ah) S_AXI_AWVALID <= 1'b0;
            if (wh) S_AXI_WVALID <= 1'b0;
        end
        if (!bh) tmo();
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        logic arh = 1'b0;
        logic rh = 1'b0;
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (int n = 0; n < 40 && !rh; n++) begin
            @(negedge CLOCK);
            arh = S_AXI_ARVALID && S_AXI_ARREADY;
            rh = S_AXI_RVALID;
            if (rh) cmp({S_AXI_RRESP, S_AXI_RDATA}, {r, 24'h000000, e});
            @(posedge CLOCK);
            if (arh) S_AXI_ARVALID <= 1'b0;
        end
        if (!rh) tmo();
        S_AXI_RREADY <= 1'b0;
    endtask

    // Writes one setup register, reads it back, then checks the ramp outputs
    task automatic wcfg(input int i, input logic [7:0] d);
        logic m;
        wr(12'h1A8 + 12'(4 * i), d, 2'h0);
        rv[i] = d;
        if (i == 0 && OPERATING_CONDITION_CODE !== 8'h03) fph = d[3:2];
        rd(12'h1A8 + 12'(4 * i), d, 2'h0);
        m = rv[1][4];
        ecfg = '{fph, rv[0][1], rv[0][0], m, m & rv[1][5], rv[1][0], rv[1][1], rv[2][3:0],
            rv[2][6:4], m ? rv[3] : 8'hA0, m ? rv[4][7:4] : 4'h1, m ? rv[4][3:0] : 4'h1,
            m ? rv[5][6:5] : 2'h1, m ? rv[5][4:0] : 5'h04};
        @(negedge CLOCK);
        cmp(RAMP_CFG, ecfg);
    endtask

    // Pin holds its level while watching, a stray late pulse still counts
    task automatic spulse(input logic pin, input logic e);
        logic seen = 1'b0;
        @(posedge CLOCK);
        SYNC_PIN <= pin;
        INTERNAL_SYNC_TICK <= !pin;
        @(posedge CLOCK);
        INTERNAL_SYNC_TICK <= 1'b0;
        repeat (8) begin
            @(negedge CLOCK);
            seen = seen | RAMP_SYNC_PULSE;
        end
        @(posedge CLOCK);
        SYNC_PIN <= 1'b0;
        cmp(seen, e);
    endtask

    task automatic irqc(input logic e);
        @(negedge CLOCK);
        cmp(IRQ, e);
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (2) @(posedge CLOCK);
        RST_N <= 1'b1;
        rd(12'h1A0, 8'h00, 2'h0);
        rd(12'h1A4, 8'h00, 2'h0);
        for (int i = 0; i < 6; i++) begin
            rd(12'h1A8 + 12'(4 * i), rv[i], 2'h0);
        end
        @(negedge CLOCK);
        cmp(RAMP_CFG, {8'h00, 4'h0, 3'h0, 8'hA0, 4'h1, 4'h1, 2'h1, 5'h04});
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            wcfg(0, 8'(i * 4));
        end
        wcfg(0, 8'hF3);
        spulse(1'b0, 1'b1);
        spulse(1'b1, 1'b0);
        wcfg(0, 8'h01);
        spulse(1'b1, 1'b1);
        spulse(1'b0, 1'b0);
        wcfg(0, 8'h06);
        spulse(1'b0, 1'b0);
        spulse(1'b1, 1'b0);
        @(posedge CLOCK);
        OPERATING_CONDITION_CODE <= 8'h03;
        wcfg(0, 8'h0C);
        @(posedge CLOCK);
        OPERATING_CONDITION_CODE <= 8'h00;
        wcfg(0, 8'h08);
        $display("test phase done");
        wcfg(1, 8'hFF);
        wcfg(2, 8'hFF);
        wcfg(3, 8'h5A);
        wcfg(4, 8'h3C);
        wcfg(5, 8'hFF);
        wcfg(1, 8'hEC);
        wcfg(2, 8'h85);
        $display("test spread done");
        for (int i = 0; i < 4; i++) begin
            @(posedge CLOCK);
            OPERATING_CONDITION_CODE <= 8'(i);
            rd(12'h1A0, 8'(i), 2'h0);
        end
        wr(12'h1A0, 8'h55, 2'h0);
        rd(12'h1A0, 8'h03, 2'h0);
        wr(12'h204, 8'h0F, 2'h0);
        wr(12'h208, 8'h01, 2'h0);
        rd(12'h200, 8'h00, 2'h0);
        @(posedge CLOCK);
        SILENCE_FLAGS <= 2'b10;
        rd(12'h1A4, 8'h01, 2'h0);
        rd(12'h200, 8'h01, 2'h0);
        irqc(1'b1);
        wr(12'h208, 8'h02, 2'h0);
        irqc(1'b0);
        @(posedge CLOCK);
        SILENCE_FLAGS <= 2'b01;
        rd(12'h1A4, 8'h02, 2'h0);
        rd(12'h200, 8'h03, 2'h0);
        irqc(1'b1);
        wr(12'h204, 8'h03, 2'h0);
        rd(12'h200, 8'h00, 2'h0);
        rd(12'h204, 8'h00, 2'h0);
        irqc(1'b0);
        wr(12'h1C0, 8'h11, 2'h2);
        rd(12'h1C0, 8'h00, 2'h2);
        $display("test status done");
        results();
    end
endmodule
`default_nettype wire
